/* inc/spi_front_pkg.sv */
// Package: constants for the serial pin front end
package spi_front_pkg;
  localparam int WORD_BITS      = 32;
  localparam int CNT_W          = 6;
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam real CLK_PERIOD_NS = 100.0;
  localparam real SYNC_NS       = 200.0;
  localparam int SYNC_CYCLES    = (SYNC_NS / CLK_PERIOD_NS) < 1.0 ? 1 : int'(SYNC_NS / CLK_PERIOD_NS);
  localparam logic [1:0] AUX_RST = 2'h0;
  // Idle levels of the synchronised link pins: cs_p, cs_n, sclk_p, sclk_n, mosi_p, mosi_n
  localparam logic [5:0] LINK_PIN_RST = 6'h20;
endpackage

/* design/pin_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // pin_sync

/* design/link_rx_select.sv */
// Link receiver: picks differential or single-ended reception for all pairs at once
`timescale 1ns/1ps
module link_rx_select #(
  parameter int PAIRS = 3
) (
  input  wire logic             diff_sel_i,
  input  wire logic [PAIRS-1:0] pos_i,
  input  wire logic [PAIRS-1:0] neg_i,
  output logic      [PAIRS-1:0] rx_o
);
  // Differential: positive above negative; single-ended: negative ignored
  always_comb begin
    if (diff_sel_i) begin
      rx_o = pos_i & ~neg_i;
    end else begin
      rx_o = pos_i;
    end
  end
endmodule // link_rx_select

/* design/spi_slave_pin_frontend.sv */
// Serial slave pin front end with conversion trigger and auxiliary outputs
`timescale 1ns/1ps
module spi_slave_pin_frontend #(
  parameter int WORD_W = spi_front_pkg::WORD_BITS,
  parameter int STIM_N = 16
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              diff_sel_i,
  input  wire logic              cs_b_p_i,
  input  wire logic              cs_b_n_i,
  input  wire logic              sclk_p_i,
  input  wire logic              sclk_n_i,
  input  wire logic              mosi_p_i,
  input  wire logic              mosi_n_i,
  output logic                   miso_p_o,
  output logic                   miso_n_o,
  input  wire logic              stim_en_i,
  input  wire logic [STIM_N-1:0] stim_req_i,
  output logic      [STIM_N-1:0] stim_drive_o,
  input  wire logic [WORD_W-1:0] tx_word_i,
  output logic      [WORD_W-1:0] rx_word_o,
  output logic                   rx_valid_o,
  output logic                   tx_load_o,
  output logic                   adc_start_o,
  input  wire logic [1:0]        aux_level_i,
  input  wire logic [1:0]        aux_drive_en_i,
  output logic      [1:0]        aux_push_pull_out_o,
  output logic      [1:0]        aux_push_pull_oe_o,
  input  wire logic              aux_open_drain_on_i,
  output logic                   aux_open_drain_out_o,
  output logic                   aux_open_drain_oe_o
);
  if (WORD_W != 32) begin : g_word_check
    $error("WORD_W must be 32");
  end
  if (STIM_N < 1) begin : g_stim_check
    $error("STIM_N must be positive");
  end

  // Pins synchronised first, then pair reception; reset values are the idle levels
  logic [5:0] pin_q;
  logic [2:0] rx_sync;
  logic       diff_sync;
  logic       stim_en_sync;

  pin_sync #(
    .WIDTH   (6),
    .RST_VAL (spi_front_pkg::LINK_PIN_RST)
  ) u_sync_link (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       ({cs_b_p_i, cs_b_n_i, sclk_p_i, sclk_n_i, mosi_p_i, mosi_n_i}),
    .q_o       (pin_q)
  );

  pin_sync #(.WIDTH(2)) u_sync_ctl (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       ({diff_sel_i, stim_en_i}),
    .q_o       ({diff_sync, stim_en_sync})
  );

  link_rx_select #(.PAIRS(3)) u_rx (
    .diff_sel_i (diff_sync),
    .pos_i      ({pin_q[5], pin_q[3], pin_q[1]}),
    .neg_i      ({pin_q[4], pin_q[2], pin_q[0]}),
    .rx_o       (rx_sync)
  );

  logic cs_b;
  logic sclk;
  logic mosi;
  assign cs_b = rx_sync[2];
  assign sclk = rx_sync[1];
  assign mosi = rx_sync[0];

  // Edge detection state
  logic cs_b_d;
  logic sclk_d;
  logic next_cs_b_d;
  logic next_sclk_d;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;

  // Edge helper: high when a level is up now and was down one cycle ago
  function automatic logic edge_up(
    input logic now_v,
    input logic was_v
  );
    return now_v & ~was_v;
  endfunction

  assign sclk_rise = edge_up(sclk, sclk_d);
  assign sclk_fall = edge_up(sclk_d, sclk);
  assign cs_fall   = edge_up(cs_b_d, cs_b);

  // Shift state
  logic [5:0]        bit_cnt;
  logic [5:0]        next_bit_cnt;
  logic [WORD_W-1:0] rx_shift;
  logic [WORD_W-1:0] next_rx_shift;
  logic [WORD_W-1:0] tx_shift;
  logic [WORD_W-1:0] next_tx_shift;
  logic [WORD_W-1:0] next_rx_word;
  logic              next_rx_valid;
  logic              next_adc_start;
  logic              next_tx_load;
  logic              miso;
  logic              next_miso;
  logic              next_miso_n;

  // Shift one bit in at the bottom of a word
  function automatic logic [WORD_W-1:0] shift_in(
    input logic [WORD_W-1:0] word_v,
    input logic              bit_v
  );
    return {word_v[WORD_W-2:0], bit_v};
  endfunction

  always_comb begin
    next_cs_b_d    = cs_b;
    next_sclk_d    = sclk;
    next_bit_cnt   = bit_cnt;
    next_rx_shift  = rx_shift;
    next_tx_shift  = tx_shift;
    next_rx_word   = rx_word_o;
    next_rx_valid  = 1'b0;
    next_adc_start = cs_fall;
    next_tx_load   = 1'b0;
    next_miso      = miso;
    if (cs_b) begin
      next_bit_cnt = spi_front_pkg::CNT_RST;
    end else if (cs_fall) begin
      next_tx_shift = tx_word_i;
      next_miso     = tx_word_i[WORD_W-1];
      next_tx_load  = 1'b1;
      next_bit_cnt  = spi_front_pkg::CNT_RST;
    end else begin
      if (sclk_rise && bit_cnt < 6'(WORD_W)) begin
        next_rx_shift = shift_in(rx_shift, mosi);
        next_bit_cnt  = bit_cnt + 6'h01;
        if (bit_cnt == 6'(WORD_W - 1)) begin
          next_rx_word  = shift_in(rx_shift, mosi);
          next_rx_valid = 1'b1;
        end
      end
      if (sclk_fall && bit_cnt != 6'h00) begin
        next_tx_shift = shift_in(tx_shift, 1'b0);
        next_miso     = tx_shift[WORD_W-2];
      end
    end
    next_miso_n = diff_sync ? ~next_miso : 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_b_d      <= 1'b1;
      sclk_d      <= 1'b0;
      bit_cnt     <= spi_front_pkg::CNT_RST;
      rx_shift    <= spi_front_pkg::WORD_RST;
      tx_shift    <= spi_front_pkg::WORD_RST;
      rx_word_o   <= spi_front_pkg::WORD_RST;
      rx_valid_o  <= 1'b0;
      adc_start_o <= 1'b0;
      tx_load_o   <= 1'b0;
      miso        <= 1'b0;
      miso_n_o    <= 1'b0;
    end else begin
      cs_b_d      <= next_cs_b_d;
      sclk_d      <= next_sclk_d;
      bit_cnt     <= next_bit_cnt;
      rx_shift    <= next_rx_shift;
      tx_shift    <= next_tx_shift;
      rx_word_o   <= next_rx_word;
      rx_valid_o  <= next_rx_valid;
      adc_start_o <= next_adc_start;
      tx_load_o   <= next_tx_load;
      miso        <= next_miso;
      miso_n_o    <= next_miso_n;
    end
  end

  // Output pair; negative member registered alongside, low in single-ended mode
  assign miso_p_o = miso;

  // Stimulator gating
  logic [STIM_N-1:0] next_stim_drive;
  always_comb begin
    next_stim_drive = stim_en_sync ? stim_req_i : '0;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stim_drive_o <= '0;
    end else begin
      stim_drive_o <= next_stim_drive;
    end
  end

  // Auxiliary outputs
  logic [1:0] next_aux_out;
  logic [1:0] next_aux_oe;
  logic       next_od_oe;
  always_comb begin
    next_aux_out = aux_level_i;
    next_aux_oe  = aux_drive_en_i;
    next_od_oe   = aux_open_drain_on_i;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aux_push_pull_out_o <= spi_front_pkg::AUX_RST;
      aux_push_pull_oe_o  <= spi_front_pkg::AUX_RST;
      aux_open_drain_oe_o <= 1'b0;
    end else begin
      aux_push_pull_out_o <= next_aux_out;
      aux_push_pull_oe_o  <= next_aux_oe;
      aux_open_drain_oe_o <= next_od_oe;
    end
  end
  assign aux_open_drain_out_o = 1'b0;

  // Checks
  AST_CNT_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cs_b |=> bit_cnt == 6'h00)
    else $error("counter not cleared");
  AST_ADC_START: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cs_fall |=> adc_start_o)
    else $error("no conversion start");
  AST_ADC_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    adc_start_o |-> $past(cs_b_d) && !$past(cs_b))
    else $error("stray conversion");
  AST_SAMPLE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !cs_b && !cs_fall && sclk_rise && bit_cnt < 6'h20 |=> rx_shift[0] == $past(mosi))
    else $error("bit not captured");
  AST_WORD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    rx_valid_o |-> $past(bit_cnt) == 6'h1f && bit_cnt == 6'h20)
    else $error("bad word length");
  AST_MISO_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !cs_b && !cs_fall && !sclk_fall |=> $stable(miso))
    else $error("miso moved off edge");
  AST_STIM_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !stim_en_sync |=> stim_drive_o == '0)
    else $error("stimulator active");
  AST_AUX: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    1'b1 |=> aux_push_pull_oe_o == $past(aux_drive_en_i))
    else $error("aux enable wrong");
  AST_OD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    aux_open_drain_on_i |=> aux_open_drain_oe_o)
    else $error("open drain not on");
  AST_CS_LOW: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cs_b |=> !rx_valid_o)
    else $error("word outside frame");
  AST_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cs_fall |=> tx_load_o && tx_shift == $past(tx_word_i))
    else $error("word not loaded");
  AST_ADC_PULSE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    adc_start_o |=> !adc_start_o)
    else $error("conversion start too long");
  AST_LOAD_PULSE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    tx_load_o |=> !tx_load_o)
    else $error("load pulse too long");
  AST_VALID_PULSE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    rx_valid_o |=> !rx_valid_o)
    else $error("word pulse too long");
  AST_CNT_MAX: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    bit_cnt <= 6'h20)
    else $error("counter beyond word");
  AST_IDLE_SHIFT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cs_b |=> $stable(rx_shift))
    else $error("shift while deselected");
  AST_IDLE_PULSE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    cs_b |=> !tx_load_o && !adc_start_o)
    else $error("pulse while deselected");
  AST_STIM_PASS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    stim_en_sync |=> stim_drive_o == $past(stim_req_i))
    else $error("stimulator request lost");
  AST_OD_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !aux_open_drain_on_i |=> !aux_open_drain_oe_o)
    else $error("open drain not off");
  AST_MISO_N: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    1'b1 |=> miso_n_o == ($past(diff_sync) ? ~miso : 1'b0))
    else $error("miso pair wrong");
  AST_CNT_STEP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !cs_b && !cs_fall && sclk_rise && bit_cnt < 6'h20 |=> bit_cnt == $past(bit_cnt) + 6'h01)
    else $error("counter did not step");
  AST_CNT_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !cs_b && !sclk_rise |=> $stable(bit_cnt))
    else $error("counter moved without edge");
  AST_MISO_STEP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !cs_b && !cs_fall && sclk_fall && bit_cnt != 6'h00 |=> miso == tx_shift[WORD_W-1])
    else $error("miso not next bit");
  AST_VALID_DATA: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    rx_valid_o |-> rx_word_o == rx_shift)
    else $error("word differs from shifter");
  AST_SE_NEG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !diff_sync |-> rx_sync == {pin_q[5], pin_q[3], pin_q[1]})
    else $error("negative pin used");
  AST_AUX_LVL: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    1'b1 |=> aux_push_pull_out_o == $past(aux_level_i))
    else $error("aux level wrong");
  AST_RX_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    1'b1 |=> rx_valid_o || $stable(rx_word_o))
    else $error("word changed without pulse");
endmodule // spi_slave_pin_frontend

/* tb/spi_master_model.sv */
// Behavioural serial master driving the link pins
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic ref_clk_i,
  input  wire logic diff_sel_i,
  input  wire logic miso_p_i,
  output logic      cs_b_p_o,
  output logic      cs_b_n_o,
  output logic      sclk_p_o,
  output logic      sclk_n_o,
  output logic      mosi_p_o,
  output logic      mosi_n_o
);
  logic cs   = 1'b1;
  logic sk   = 1'b0;
  logic mo   = 1'b0;
  logic junk = 1'b0;
  always @(negedge ref_clk_i) junk <= ~junk;
  assign cs_b_p_o = cs;
  assign sclk_p_o = sk;
  assign mosi_p_o = mo;
  // Negative members carry a toggling pattern in single-ended mode
  assign cs_b_n_o = diff_sel_i ? ~cs : junk;
  assign sclk_n_o = diff_sel_i ? ~sk : ~junk;
  assign mosi_n_o = diff_sel_i ? ~mo : junk;
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Clock pulses with chip select high
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      tick(4);
      sk = 1'b1;
      tick(4);
      sk = 1'b0;
    end
  endtask
  task automatic frame(input logic [31:0] w, input int nbits, output logic [31:0] r);
    r = 32'h0000_0000;
    tick(1);
    cs = 1'b0;
    tick(4);
    for (int i = 0; i < nbits; i++) begin
      mo = w[31 - (i % 32)];
      tick(4);
      sk = 1'b1;
      r = {r[30:0], miso_p_i};
      tick(4);
      sk = 1'b0;
    end
    tick(4);
    cs = 1'b1;
    mo = ~mo;
    tick(8);
  endtask
endmodule // spi_master_model

/* tb/spi_slave_pin_frontend_tb.sv */
// Self-checking bench for the serial pin front end
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module spi_slave_pin_frontend_tb;
  logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, diff_sel_i = 1'b0, stim_en_i = 1'b0;
  logic        aod_on = 1'b0, cs_p, cs_n, sk_p, sk_n, mo_p, mo_n, miso_p, miso_n;
  logic        rx_valid, tx_load, adc_start, aod_out, aod_oe;
  logic [15:0] stim_req = 16'h0000, stim_drive;
  logic [31:0] tx_word = 32'h0000_0000, rx_word, r;
  logic [1:0]  aux_lvl = 2'h0, aux_en = 2'h0, pp_out, pp_oe;
  int          miscompares = 0, n_checks = 0, seed = 67, n_adc = 0, n_load = 0, n_valid = 0;
  int          n_idle = 0;
  logic [31:0] exp_q[$];
  always #50 ref_clk_i = ~ref_clk_i;
  spi_master_model u_mst (.ref_clk_i(ref_clk_i), .diff_sel_i(diff_sel_i), .miso_p_i(miso_p),
    .cs_b_p_o(cs_p), .cs_b_n_o(cs_n), .sclk_p_o(sk_p), .sclk_n_o(sk_n),
    .mosi_p_o(mo_p), .mosi_n_o(mo_n));
  spi_slave_pin_frontend u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .diff_sel_i(diff_sel_i), .cs_b_p_i(cs_p), .cs_b_n_i(cs_n), .sclk_p_i(sk_p),
    .sclk_n_i(sk_n), .mosi_p_i(mo_p), .mosi_n_i(mo_n), .miso_p_o(miso_p), .miso_n_o(miso_n),
    .stim_en_i(stim_en_i), .stim_req_i(stim_req), .stim_drive_o(stim_drive),
    .tx_word_i(tx_word), .rx_word_o(rx_word), .rx_valid_o(rx_valid), .tx_load_o(tx_load),
    .adc_start_o(adc_start), .aux_level_i(aux_lvl), .aux_drive_en_i(aux_en),
    .aux_push_pull_out_o(pp_out), .aux_push_pull_oe_o(pp_oe),
    .aux_open_drain_on_i(aod_on), .aux_open_drain_out_o(aod_out),
    .aux_open_drain_oe_o(aod_oe));
  always @(posedge ref_clk_i) begin
    n_adc = n_adc + (adc_start === 1'b1);
    n_load = n_load + (tx_load === 1'b1);
    if (rx_valid === 1'b1) begin
      n_valid++;
      if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
      else `CHK(rx_word, exp_q.pop_front())
    end
  end
  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run_frame(input int nbits);
    logic [31:0] w;
    int          a0, v0, l0;
    w = $random(seed);
    tx_word = $random(seed);
    a0 = n_adc;
    v0 = n_valid;
    l0 = n_load;
    if (nbits >= 32) exp_q.push_back(w);
    u_mst.frame(w, nbits, r);
    `CHK(n_adc, a0 + 1)
    `CHK(n_load, l0 + 1)
    `CHK(n_valid, v0 + (nbits >= 32))
    `CHK(exp_q.size(), 0)
    if (nbits <= 32) `CHK(r, tx_word >> (32 - nbits))
    `CHK(miso_n, diff_sel_i ? ~miso_p : 1'b0)
  endtask
  task automatic pins_check();
    @(negedge ref_clk_i);
    {stim_en_i, aod_on, aux_lvl, aux_en} = 6'($random(seed));
    stim_req = 16'($random(seed));
    repeat (4) @(negedge ref_clk_i);
    `CHK(stim_drive, stim_en_i ? stim_req : 16'h0000)
    `CHK({pp_out, pp_oe}, {aux_lvl, aux_en})
    `CHK({aod_out, aod_oe}, {1'b0, aod_on})
  endtask
  initial begin
    repeat (10) @(negedge ref_clk_i);
    for (int m = 0; m < 2; m++) begin
      rst_b_i = 1'b1;
      diff_sel_i = m[0];
      repeat (9) @(negedge ref_clk_i);
      u_mst.stray(3);
      `CHK(n_adc + n_load + n_valid, n_idle)
      run_frame(32);
      run_frame(32);
      run_frame(20);
      run_frame(34);
      repeat (4) pins_check();
      rst_b_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      `CHK({stim_drive, pp_oe, aod_oe, miso_p}, 20'h00000)
      n_idle = n_adc + n_load + n_valid;
    end
    final_report();
  end
  initial begin
    #2000000;
    miscompares++;
    final_report();
  end
endmodule // spi_slave_pin_frontend_tb
